/* File: sfr_pkg.sv */
// package of constants and types for the shared fifo ram block
package sfr_pkg;
	localparam int SFR_DATA_W      = 64;
	localparam int SFR_ADDR_W      = 9;
	localparam int SFR_WORDS       = 432;
	localparam logic [8:0] SFR_RX_BASE  = 9'h000;
	localparam logic [8:0] SFR_TX_BASE  = 9'h0C0;
	localparam logic [8:0] SFR_LST_BASE = 9'h180;
	localparam logic [8:0] SFR_FIFO_WORDS = 9'h0C0;
	localparam logic [8:0] SFR_LST_WORDS  = 9'h010;
	localparam logic [1:0] SFR_SLOT_RST   = 2'h0;
	localparam int SFR_FIFO_DEPTH  = 4;

	typedef enum logic [1:0] {
		SFR_OWN_HOST  = 2'b00,
		SFR_OWN_ENG   = 2'b01,
		SFR_OWN_SPARE = 2'b10
	} sfr_owner_type;
endpackage

/* File: sfr_stream_if.sv */
// valid/ready word stream carrier between the block's modules
`timescale 1ns/1ps
interface sfr_stream_if #(parameter int W = 64);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src  (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

/* File: sfr_fifo.sv */
// small parameterised valid/ready fifo
`timescale 1ns/1ps
module sfr_fifo #(
	parameter int W = 64,
	parameter int D = 4
) (
	input  wire logic clk,
	input  wire logic nrst,
	sfr_stream_if.sink in_s,
	sfr_stream_if.src  out_s
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	logic          ready_reg;
	logic          push;
	logic          pop;

	// ready is registered from the next fill level so the top sees a flop output
	assign cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign in_s.ready  = ready_reg;
	assign out_s.valid = (cnt_reg != '0);
	assign out_s.data  = mem_reg[rp_reg];
	assign push = in_s.valid && in_s.ready;
	assign pop  = out_s.valid && out_s.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wp_reg] <= in_s.data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg   <= '0;
			ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg   <= cnt_next;
			ready_reg <= (cnt_next != (AW+1)'(D));
		end
	end
endmodule

/* File: sfr_shared_fifo_ram.sv */
// shared fifo ram with tdm slots, fifo pointer set and diagnostic access
// Functional notes
// - all ram reads and writes happen on the single bus clock
// - ram access follows a fixed slot schedule, no arbiter
// - host owns every other slot, moving 64 bits per slot
// - frame engine owns a quarter of slots, port up to 64 bits
// - spare slots may be given to the frame engine
// - internal diagnostic bus can read and write the ram in spare slots not given to the engine
// - 3.375K bytes: two 1.5K fifos and three 128-byte lists
// - circular fifos kept by pointer and counter registers, visible to both
// - each fifo holds one full maximum-length frame
`timescale 1ns/1ps
module sfr_shared_fifo_ram import sfr_pkg::*; #(
	parameter int ENG_W = 64
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// configuration
	input  wire logic                  spare_to_engine,
	// host bus interface: host_fifo unused, reads take rx and writes fill tx, list access via host_list and addr
	input  wire logic                  host_req,
	input  wire logic                  host_we,
	input  wire logic                  host_fifo,
	input  wire logic                  host_list,
	input  wire logic [SFR_ADDR_W-1:0] host_addr,
	input  wire logic [SFR_DATA_W-1:0] host_wdata,
	output logic                       host_done,
	output logic [SFR_DATA_W-1:0]      host_rdata,
	// frame engine, write stream feeds the rx fifo through a buffer
	input  wire logic                  eng_wvalid,
	input  wire logic [ENG_W-1:0]      eng_wdata,
	output logic                       eng_wready,
	input  wire logic                  eng_rreq,
	output logic                       eng_rvalid,
	output logic [ENG_W-1:0]           eng_rdata,
	// diagnostic bus
	input  wire logic                  diag_req,
	input  wire logic                  diag_we,
	input  wire logic [SFR_ADDR_W-1:0] diag_addr,
	input  wire logic [SFR_DATA_W-1:0] diag_wdata,
	output logic                       diag_done,
	output logic [SFR_DATA_W-1:0]      diag_rdata,
	// fifo pointer set
	output logic [SFR_ADDR_W-1:0]      rx_count,
	output logic [SFR_ADDR_W-1:0]      tx_count
);
	logic [SFR_DATA_W-1:0] ram_reg [SFR_WORDS];
	logic [1:0]            slot_reg;
	sfr_owner_type         owner;
	logic [SFR_ADDR_W-1:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
	logic                  eng_slot, host_slot, diag_slot;
	logic                  rx_full, tx_empty, rx_empty, tx_full;
	logic                  eng_wr, eng_rd, host_wr, host_rd, diag_acc;
	logic [SFR_ADDR_W-1:0] ram_addr;
	logic [SFR_DATA_W-1:0] ram_wdata;
	logic                  ram_we;
	logic                  ram_en;

	sfr_stream_if #(.W(ENG_W)) eng_in ();
	sfr_stream_if #(.W(ENG_W)) eng_out ();

	assign eng_in.valid = eng_wvalid;
	assign eng_in.data  = eng_wdata;
	assign eng_wready   = eng_in.ready;

	// buffer absorbs engine bursts while its slot is not up
	sfr_fifo #(.W(ENG_W), .D(SFR_FIFO_DEPTH)) u_eng_buf (
		.clk   (clk),
		.nrst  (nrst),
		.in_s  (eng_in),
		.out_s (eng_out)
	);

	// slot counter, repeats every four cycles
	always_ff @(posedge clk) begin
		if (!nrst) begin
			slot_reg <= SFR_SLOT_RST;
		end else begin
			slot_reg <= slot_reg + 2'h1;
		end
	end

	always_comb begin
		case (slot_reg)
			2'h0, 2'h2: owner = SFR_OWN_HOST;
			2'h1:       owner = SFR_OWN_ENG;
			2'h3:       owner = spare_to_engine ? SFR_OWN_ENG : SFR_OWN_SPARE;
			default:    owner = SFR_OWN_SPARE;
		endcase
	end

	assign host_slot = (owner == SFR_OWN_HOST);
	assign eng_slot  = (owner == SFR_OWN_ENG);
	assign diag_slot = (owner == SFR_OWN_SPARE);

	// pointer set status, counts are up/down fill counters
	assign rx_full  = (rx_count == SFR_FIFO_WORDS);
	assign rx_empty = (rx_count == '0);
	assign tx_full  = (tx_count == SFR_FIFO_WORDS);
	assign tx_empty = (tx_count == '0);

	// engine writes rx, reads tx; host reads rx, writes tx
	assign eng_wr  = eng_slot && eng_out.valid && !rx_full;
	assign eng_rd  = eng_slot && !eng_out.valid && eng_rreq && !tx_empty;
	assign host_wr = host_slot && host_req && host_we && (host_list || !tx_full);
	assign host_rd = host_slot && host_req && !host_we && (host_list || !rx_empty);
	assign diag_acc = diag_slot && diag_req;
	assign eng_out.ready = eng_wr;

	always_comb begin
		ram_addr  = '0;
		ram_wdata = '0;
		ram_we    = 1'b0;
		ram_en    = 1'b0;
		if (eng_wr) begin
			ram_addr  = SFR_RX_BASE + rx_wp_reg;
			ram_wdata = SFR_DATA_W'(eng_out.data);
			ram_we    = 1'b1;
			ram_en    = 1'b1;
		end else if (eng_rd) begin
			ram_addr = SFR_TX_BASE + tx_rp_reg;
			ram_en   = 1'b1;
		end else if (host_wr || host_rd) begin
			if (host_list) begin
				ram_addr = SFR_LST_BASE + 9'(host_addr % (9'h3 * SFR_LST_WORDS));
			end else if (host_wr) begin
				ram_addr = SFR_TX_BASE + tx_wp_reg;
			end else begin
				ram_addr = SFR_RX_BASE + rx_rp_reg;
			end
			ram_wdata = host_wdata;
			ram_we    = host_wr;
			ram_en    = 1'b1;
		end else if (diag_acc) begin
			ram_addr  = (diag_addr < 9'(SFR_WORDS)) ? diag_addr : '0;
			ram_wdata = diag_wdata;
			ram_we    = diag_we;
			ram_en    = 1'b1;
		end
	end

	// array port, one access per cycle on the single clock
	always_ff @(posedge clk) begin
		if (ram_en && ram_we) begin
			ram_reg[ram_addr] <= ram_wdata;
		end
	end

	logic [SFR_DATA_W-1:0] ram_q;
	assign ram_q = ram_reg[ram_addr];

	// circular pointers, wrap at the fifo size
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
		end else begin
			if (eng_wr) begin
				rx_wp_reg <= (rx_wp_reg == SFR_FIFO_WORDS - 9'h1) ? '0 : rx_wp_reg + 9'h1;
			end
			if (host_rd && !host_list) begin
				rx_rp_reg <= (rx_rp_reg == SFR_FIFO_WORDS - 9'h1) ? '0 : rx_rp_reg + 9'h1;
			end
			if (host_wr && !host_list) begin
				tx_wp_reg <= (tx_wp_reg == SFR_FIFO_WORDS - 9'h1) ? '0 : tx_wp_reg + 9'h1;
			end
			if (eng_rd) begin
				tx_rp_reg <= (tx_rp_reg == SFR_FIFO_WORDS - 9'h1) ? '0 : tx_rp_reg + 9'h1;
			end
		end
	end

	// fill counters shared by both parties
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_count <= '0;
			tx_count <= '0;
		end else begin
			rx_count <= rx_count + 9'(eng_wr) - 9'(host_rd && !host_list);
			tx_count <= tx_count + 9'(host_wr && !host_list) - 9'(eng_rd);
		end
	end

	// registered answers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			host_done  <= 1'b0;
			host_rdata <= '0;
			eng_rvalid <= 1'b0;
			eng_rdata  <= '0;
			diag_done  <= 1'b0;
			diag_rdata <= '0;
		end else begin
			host_done  <= host_wr || host_rd;
			eng_rvalid <= eng_rd;
			diag_done  <= diag_acc && !eng_wr && !eng_rd;
			if (host_rd) begin
				host_rdata <= ram_q;
			end
			if (eng_rd) begin
				eng_rdata <= ram_q[ENG_W-1:0];
			end
			if (diag_acc && !diag_we) begin
				diag_rdata <= ram_q;
			end
		end
	end
endmodule

/* File: sfr_asserts.sv */
// port assertions for the shared fifo ram
`timescale 1ns/1ps
module sfr_asserts import sfr_pkg::*; (
	// clock, reset and configuration
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic                  spare_to_engine,
	// host side
	input wire logic                  host_req,
	input wire logic                  host_we,
	input wire logic                  host_list,
	input wire logic                  host_done,
	// engine, diagnostic and fill levels
	input wire logic                  eng_rvalid,
	input wire logic                  diag_done,
	input wire logic [SFR_ADDR_W-1:0] rx_count,
	input wire logic [SFR_ADDR_W-1:0] tx_count
);
	logic [1:0] slot_reg;
	// mirrors the slot counter, which restarts at the host slot
	always_ff @(posedge clk) slot_reg <= nrst ? slot_reg + 2'h1 : SFR_SLOT_RST;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_host_slot; host_done |-> slot_reg[0]; endproperty
	a_host_slot: assert property (p_host_slot) else $error("host done off slot");
	property p_eng_slot;
		eng_rvalid |-> slot_reg == 2'h2 || (slot_reg == 2'h0 && $past(spare_to_engine));
	endproperty
	a_eng_slot: assert property (p_eng_slot) else $error("engine read off slot");
	property p_diag_slot; diag_done |-> slot_reg == 2'h0 && !$past(spare_to_engine); endproperty
	a_diag_slot: assert property (p_diag_slot) else $error("diag done off slot");
	property p_cause; host_done |-> $past(host_req); endproperty
	a_cause: assert property (p_cause) else $error("host done without request");
	property p_max; rx_count <= SFR_FIFO_WORDS && tx_count <= SFR_FIFO_WORDS; endproperty
	a_max: assert property (p_max) else $error("fifo fill above one frame");
	property p_rx_dec;
		host_done && !$past(host_we) && !$past(host_list) |-> rx_count == $past(rx_count) - 9'h001;
	endproperty
	a_rx_dec: assert property (p_rx_dec) else $error("rx count not lowered");
	property p_tx_dec; eng_rvalid |-> tx_count == $past(tx_count) - 9'h001; endproperty
	a_tx_dec: assert property (p_tx_dec) else $error("tx count not lowered");
	property p_take;
		host_req && !host_we && !host_list && slot_reg == 2'h0 && rx_count != 9'h000 |=> host_done;
	endproperty
	a_take: assert property (p_take) else $error("host slot not served");
	c_spare: cover property (eng_rvalid && slot_reg == 2'h0);
	c_diag: cover property (diag_done);
	c_read: cover property (host_done && $past(rx_count) != 9'h000);
endmodule
bind sfr_shared_fifo_ram sfr_asserts u_chk (.clk(clk), .nrst(nrst),
	.spare_to_engine(spare_to_engine), .host_req(host_req), .host_we(host_we),
	.host_list(host_list), .host_done(host_done), .eng_rvalid(eng_rvalid),
	.diag_done(diag_done), .rx_count(rx_count), .tx_count(tx_count));

/* File: sfr_eng_model.sv */
// frame engine model pushing a run of words into the write stream
`timescale 1ns/1ps
module sfr_eng_model import sfr_pkg::*; (
	// clock and control
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic                  go,
	input wire logic                  slow,
	input wire logic [3:0]            n_words,
	// write stream
	output logic                      eng_wvalid,
	output logic [SFR_DATA_W-1:0]     eng_wdata,
	input wire logic                  eng_wready
);
	logic [3:0] left_reg;
	logic [3:0] idx_reg;
	logic       gap_reg;
	// idle data is inverted so a stale word is never mistaken for a live one
	assign eng_wvalid = left_reg != 4'h0 && !gap_reg;
	assign eng_wdata = eng_wvalid ? {60'hA5A5_0000_0000_000, idx_reg} : ~{60'h0, idx_reg};
	always_ff @(posedge clk) begin
		if (!nrst) begin
			left_reg <= 4'h0;
			idx_reg <= 4'h0;
			gap_reg <= 1'b0;
		end else if (go) begin
			left_reg <= n_words;
			idx_reg <= 4'h0;
		end else if (eng_wvalid && eng_wready) begin
			left_reg <= left_reg - 4'h1;
			idx_reg <= idx_reg + 4'h1;
			gap_reg <= slow;
		end else gap_reg <= 1'b0;
	end
endmodule

/* File: testbench.sv */
// self-checking bench for the shared fifo ram
`timescale 1ns/1ps
module testbench import sfr_pkg::*; ;
	logic                  clk = 0, nrst = 0, spare = 0, go = 0, slow = 0;
	logic                  h_req = 0, we_v = 0, h_list = 0, e_rreq = 0, d_req = 0;
	logic [SFR_ADDR_W-1:0] a_v = 0, rxc, txc;
	logic [SFR_DATA_W-1:0] wd_v = 0, h_rd, d_rd, e_rd, e_wd, got;
	logic                  h_done, d_done, e_rv, e_wv, e_wr;
	logic [3:0]            nw = 0;
	int                    mismatches = 0, n_compared = 0, cyc = 0;
	always #12.5 clk = ~clk;
	sfr_shared_fifo_ram dut (.clk(clk), .nrst(nrst), .spare_to_engine(spare),
		.host_req(h_req), .host_we(we_v), .host_fifo(1'b0), .host_list(h_list),
		.host_addr(a_v), .host_wdata(wd_v), .host_done(h_done), .host_rdata(h_rd),
		.eng_wvalid(e_wv), .eng_wdata(e_wd), .eng_wready(e_wr), .eng_rreq(e_rreq),
		.eng_rvalid(e_rv), .eng_rdata(e_rd), .diag_req(d_req), .diag_we(we_v),
		.diag_addr(a_v), .diag_wdata(wd_v), .diag_done(d_done), .diag_rdata(d_rd),
		.rx_count(rxc), .tx_count(txc));
	sfr_eng_model u_eng (.clk(clk), .nrst(nrst), .go(go), .slow(slow), .n_words(nw),
		.eng_wvalid(e_wv), .eng_wdata(e_wd), .eng_wready(e_wr));
	task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one host or diagnostic access; ok says whether it may complete
	task automatic acc(bit dg, logic we, logic ls, logic [8:0] a, logic [63:0] d, bit ok);
		int n;
		n = 0;
		@(posedge clk);
		h_req <= !dg;
		d_req <= dg;
		we_v <= we;
		h_list <= ls;
		a_v <= a;
		wd_v <= d;
		do @(negedge clk); while ((dg ? d_done : h_done) !== 1'b1 && ++n < 20);
		chk("done", dg ? d_done : h_done, ok);
		got = dg ? d_rd : h_rd;
		@(posedge clk);
		h_req <= 0;
		d_req <= 0;
	endtask
	task automatic t_reset;
		repeat (16) @(posedge clk);
		nrst <= 1;
		@(negedge clk);
		chk("wready", e_wr, 1);
		chk("counts", {rxc, txc}, 0);
	endtask
	task automatic t_tx;
		int n;
		@(posedge clk);
		spare <= 1;
		for (int i = 0; i < 3; i++) acc(0, 1, 0, 0, 64'h0123_0000_0000_0000 + i, 1);
		@(negedge clk);
		chk("tx count", txc, 3);
		@(posedge clk);
		e_rreq <= 1;
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do @(negedge clk); while (e_rv !== 1'b1 && ++n < 20);
			chk("eng word", e_rd, 64'h0123_0000_0000_0000 + i);
		end
		@(posedge clk);
		e_rreq <= 0;
	endtask
	task automatic t_rx;
		int n;
		bit stalled;
		@(posedge clk);
		spare <= 0;
		slow <= 1;
		nw <= 8;
		go <= 1;
		@(posedge clk);
		go <= 0;
		n = 0;
		stalled = 0;
		do begin
			@(negedge clk);
			stalled |= !e_wr;
		end while (rxc !== 9'h008 && ++n < 100);
		chk("buffer stall", stalled, 1);
		for (int i = 0; i < 8; i++) begin
			acc(0, 0, 0, 0, 0, 1);
			chk("rx word", got, {60'hA5A5_0000_0000_000, 4'(i)});
		end
		acc(0, 0, 0, 0, 0, 0);
		chk("rx count", {rxc, txc}, 0);
	endtask
	task automatic t_lst;
		acc(0, 1, 1, 9'h005, 64'hC0DE_0000_0000_0005, 1);
		acc(1, 0, 0, SFR_LST_BASE + 9'h005, 0, 1);
		chk("diag list", got, 64'hC0DE_0000_0000_0005);
		acc(1, 1, 0, 9'h1AF, 64'hD1A6_0000_0000_01AF, 1);
		acc(0, 0, 1, 9'h02F, 0, 1);
		chk("host list", got, 64'hD1A6_0000_0000_01AF);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		t_reset;
		t_tx;
		t_rx;
		t_lst;
		print_verdict;
	end
endmodule
